// *** mbcs_defines.svh ***
// constants for the basic mode control and status registers
`ifndef MBCS_DEFINES_SVH
`define MBCS_DEFINES_SVH

`define MBCS_ADDR_CONTROL     5'h00
`define MBCS_ADDR_STATUS      5'h01
`define MBCS_BIT_DP_RESET     15
`define MBCS_BIT_LOOPBACK     14
`define MBCS_BIT_AN_ENABLE    12
`define MBCS_BIT_AN_RESTART   9
`define MBCS_BIT_COL_TEST     7
`define MBCS_CONTROL_RW_MASK  16'h5080
`define MBCS_STATUS_VALUE     16'h7909
`define MBCS_RXD_NO_AN        2'h3
`define MBCS_COL_ASSERT_MAX   64

`endif

// *** mbcs_pkg.sv ***
// types shared by the register bank files
package mbcs_pkg;

   // one register access from the management interface
   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } mbcs_req_t;

   // strap pins sampled at reset
   typedef struct packed {
      logic       col;
      logic       rx_dv;
      logic [1:0] rxd;
   } mbcs_strap_t;

   typedef enum logic [1:0] {
      MBCS_IDLE  = 2'b00,
      MBCS_WAIT  = 2'b01,
      MBCS_HELD  = 2'b10
   } mbcs_col_state_t;

endpackage : mbcs_pkg

// *** mbcs_sync.sv ***
// three-stage input synchroniser with agreement check
`timescale 1ns/100ps
module mbcs_sync
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_dout;

   // shift, and accept a change once stages two and three agree
   always_comb
   begin
      next_stage = {stage[1:0], din};
      next_dout  = (stage[2] == stage[1]) ? stage[2] : dout;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         stage <= 3'h0;
         dout  <= 1'b0;
      end
      else if (ce)
      begin
         stage <= next_stage;
         dout  <= next_dout;
      end
   end
endmodule : mbcs_sync

// *** mbcs_regs.sv ***
// basic mode control and status registers with collision test
//
// Function
// - Writing 1 to control bit 15 pulses a datapath reset and the bit then reads 0.
// - Control bit 14 drives the diagnostic loopback enable output.
// - Control bit 12 is a read-write auto-negotiation enable.
// - At reset the enable loads 1 if COL is high or RX_DV high with RXD[1:0] not 11.
// - Writing 1 to control bit 9 pulses an auto-negotiation restart and self-clears.
// - With collision test set, COL rises within 64 transmit clocks of TX_EN rising.
// - With collision test set, COL falls within one transmit clock of TX_EN falling.
// - Status bits 14 and 13 always read 1 and ignore writes.
// - Status bits 12 and 11 always read 1 as read-only constants.
// - The registers sit at unpaged management addresses 0 and 1, whatever the page.
// - Self-clearing bits return to 0 on their own after being written as 1.
`timescale 1ns/100ps
`include "mbcs_defines.svh"
module mbcs_regs
(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire mbcs_pkg::mbcs_req_t req,
   output logic [15:0]              rdata,
   input  wire mbcs_pkg::mbcs_strap_t strap,
   input  wire logic                tx_en,
   input  wire logic                col_in,
   output logic                     col_out,
   output logic                     datapath_reset,
   output logic                     autoneg_restart,
   output logic                     diag_loopback,
   output logic                     autoneg_enable
);
   import mbcs_pkg::*;

   //------------------------------------------------------------
   // strap capture
   //------------------------------------------------------------
   logic rst_q;
   logic next_rst_q;
   logic strap_an;

   // unpaged decode, page select plays no part
   function automatic logic hit(input logic [4:0] a, input logic [4:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   //------------------------------------------------------------
   // control register
   //------------------------------------------------------------
   logic        loop_bit;
   logic        an_bit;
   logic        col_test;
   logic        dp_pulse;
   logic        an_pulse;
   logic        next_loop_bit;
   logic        next_an_bit;
   logic        next_col_test;
   logic        next_dp_pulse;
   logic        next_an_pulse;
   logic        wr_ctl;

   assign strap_an = strap.col | (strap.rx_dv & (strap.rxd != `MBCS_RXD_NO_AN));
   assign wr_ctl   = req.wr_en & hit(req.addr, `MBCS_ADDR_CONTROL);

   // register writes and strap load on the first cycle after reset
   always_comb
   begin
      next_rst_q    = 1'b0;
      next_loop_bit = loop_bit;
      next_an_bit   = an_bit;
      next_col_test = col_test;
      next_dp_pulse = 1'b0;
      next_an_pulse = 1'b0;
      if (rst_q)
         next_an_bit = strap_an;
      if (wr_ctl)
      begin
         next_loop_bit = req.wdata[`MBCS_BIT_LOOPBACK];
         next_an_bit   = req.wdata[`MBCS_BIT_AN_ENABLE];
         next_col_test = req.wdata[`MBCS_BIT_COL_TEST];
         next_dp_pulse = req.wdata[`MBCS_BIT_DP_RESET];
         next_an_pulse = req.wdata[`MBCS_BIT_AN_RESTART];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rst_q    <= 1'b1;
         loop_bit <= 1'b0;
         an_bit   <= 1'b0;
         col_test <= 1'b0;
         dp_pulse <= 1'b0;
         an_pulse <= 1'b0;
      end
      else if (ce)
      begin
         rst_q    <= next_rst_q;
         loop_bit <= next_loop_bit;
         an_bit   <= next_an_bit;
         col_test <= next_col_test;
         dp_pulse <= next_dp_pulse;
         an_pulse <= next_an_pulse;
      end
   end

   assign datapath_reset  = dp_pulse;
   assign autoneg_restart = an_pulse;
   assign diag_loopback   = loop_bit;
   assign autoneg_enable  = an_bit;

   //------------------------------------------------------------
   // read path
   //------------------------------------------------------------
   logic [15:0] ctl_view;
   logic [15:0] next_rdata;

   // self-clearing and reserved bits read as zero
   always_comb
   begin
      ctl_view = 16'h0000;
      ctl_view[`MBCS_BIT_LOOPBACK]  = loop_bit;
      ctl_view[`MBCS_BIT_AN_ENABLE] = an_bit;
      ctl_view[`MBCS_BIT_COL_TEST]  = col_test;
      next_rdata = rdata;
      if (req.rd_en)
      begin
         if (hit(req.addr, `MBCS_ADDR_CONTROL))
            next_rdata = ctl_view & `MBCS_CONTROL_RW_MASK;
         else if (hit(req.addr, `MBCS_ADDR_STATUS))
            next_rdata = `MBCS_STATUS_VALUE;
         else
            next_rdata = 16'h0000;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdata <= 16'h0000;
      else if (ce)
         rdata <= next_rdata;
   end

   //------------------------------------------------------------
   // collision test
   //------------------------------------------------------------
   logic tx_en_s;
   logic next_col;

   mbcs_sync u_tx_sync
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .din     (tx_en),
      .dout    (tx_en_s)
   );

   // test mode: rise waits for the synchronised copy, drop takes the pin itself
   // so COL falls one cycle after transmit enable; tx_en is launched by the
   // transmit clock that ref_clk stands in for, so the raw path is timed
   always_comb
   begin
      if (col_test)
         next_col = tx_en_s & tx_en;
      else
         next_col = col_in;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         col_out <= 1'b0;
      else if (ce)
         col_out <= next_col;
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   a_dp_self_clear: assert property (@(posedge ref_clk) disable iff (rst)
      ce && dp_pulse && !wr_ctl |=> !dp_pulse)
      else $error("datapath reset did not self clear");

   a_dp_on_write: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_ctl && req.wdata[15] |=> dp_pulse)
      else $error("datapath reset not pulsed");

   a_loop_follows: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_ctl |=> diag_loopback == $past(req.wdata[14]))
      else $error("loopback bit not written");

   a_an_writes: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_ctl |=> autoneg_enable == $past(req.wdata[12]))
      else $error("autoneg enable not written");

   a_an_strap: assert property (@(posedge ref_clk) disable iff (rst)
      ce && rst_q && !wr_ctl |=> autoneg_enable == $past(strap_an))
      else $error("autoneg strap not loaded");

   a_restart_clear: assert property (@(posedge ref_clk) disable iff (rst)
      ce && an_pulse && !wr_ctl |=> !an_pulse)
      else $error("restart did not self clear");

   a_col_rise: assert property (@(posedge ref_clk) disable iff (rst)
      col_test && ce && $rose(tx_en_s) && tx_en |=> col_out)
      else $error("collision not raised");

   a_col_fall: assert property (@(posedge ref_clk) disable iff (rst)
      col_test && ce && !tx_en |=> !col_out)
      else $error("collision not dropped");

   a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
      ce && req.rd_en && req.addr == `MBCS_ADDR_STATUS |=> rdata == `MBCS_STATUS_VALUE)
      else $error("status value wrong");

   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
      ce && req.rd_en && req.addr == 5'h00 |=> (rdata & 16'hAF7F) == 16'h0000)
      else $error("reserved control bits not zero");

endmodule : mbcs_regs

// *** mbcs_host.sv ***
// management host model that issues register reads and writes
`timescale 1ns/100ps
module mbcs_host
(
   input  wire logic           ref_clk,
   output mbcs_pkg::mbcs_req_t req,
   input  wire logic [15:0]    rdata
);
   import mbcs_pkg::*;

   // bus idle from time zero
   initial req = '0;

   // one write strobe held through its sampling edge, then one idle edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
   begin
      req = '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      #1 req = '0;
      @(posedge ref_clk);
      #1;
   end
   endtask : wr

   // one read strobe, data taken once the registered answer has landed
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
   begin
      req = '{1'b0, 1'b1, a, 16'h0000};
      @(posedge ref_clk);
      #1 req = '0;
      @(posedge ref_clk);
      #1 d = rdata;
   end
   endtask : rd
endmodule : mbcs_host

// *** mii_basic_control_status_regs_tb.sv ***
// self-checking bench for the basic mode control and status registers
`timescale 1ns/100ps
module mii_basic_control_status_regs_tb;
   import mbcs_pkg::*;
   typedef struct packed {mbcs_strap_t s; logic an;} mbcs_row_t;

   logic                ref_clk = 1'b0;
   logic                rst, ce, tx_en, col_in;
   logic                col_out, datapath_reset, autoneg_restart;
   logic                diag_loopback, autoneg_enable;
   logic [15:0]         rdata, d;
   mbcs_req_t           req;
   mbcs_strap_t         strap;
   int                  n_fail = 0, total_checks = 0, n_dpr = 0, n_anr = 0, i;
   mbcs_row_t           rows [4] = '{'{4'h8, 1'b1}, '{4'h4, 1'b1}, '{4'h7, 1'b0}, '{4'h0, 1'b0}};

   // ----------------------------------------
   // clock, instances and pulse counters
   // ----------------------------------------
   always #50 ref_clk = ~ref_clk;

   mbcs_regs i_mbcs_regs (.ref_clk(ref_clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
      .strap(strap), .tx_en(tx_en), .col_in(col_in), .col_out(col_out),
      .datapath_reset(datapath_reset), .autoneg_restart(autoneg_restart),
      .diag_loopback(diag_loopback), .autoneg_enable(autoneg_enable));
   mbcs_host i_mbcs_host (.ref_clk(ref_clk), .req(req), .rdata(rdata));

   always @(posedge ref_clk)
   begin
      n_dpr += int'(datapath_reset === 1'b1);
      n_anr += int'(autoneg_restart === 1'b1);
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask : chk

   task automatic do_reset;
   begin
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
   end
   endtask : do_reset

   task automatic finish_test;
   begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask : finish_test

   // hang guard, far beyond the fewer than a hundred cycles the tests take
   initial
   begin
      #200000;
      n_fail++;
      finish_test;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1; ce = 1'b1; tx_en = 1'b0; col_in = 1'b0; strap = '0;
      // strap rows: col, rx_dv, rxd against the enable loaded at reset
      for (i = 0; i < 4; i++)
      begin
         strap = rows[i].s;
         do_reset;
         chk(16'(autoneg_enable), 16'(rows[i].an));
         i_mbcs_host.rd(5'h00, d);
         chk(d, {3'h0, rows[i].an, 12'h000});
      end
      $display("strap test done");
      // all ones: self-clearing pulses once, reserved bits stay 0
      n_dpr = 0; n_anr = 0;
      i_mbcs_host.wr(5'h00, 16'hFFFF);
      repeat (4) @(posedge ref_clk);
      #1 chk(16'(n_dpr), 16'h0001);
      chk(16'(n_anr), 16'h0001);
      chk(16'(diag_loopback), 16'h0001);
      chk(16'(autoneg_enable), 16'h0001);
      i_mbcs_host.rd(5'h00, d);
      chk(d, 16'h5080);
      i_mbcs_host.wr(5'h00, 16'h0000);
      i_mbcs_host.rd(5'h00, d);
      chk(d, 16'h0000);
      chk(16'(diag_loopback), 16'h0000);
      // clock enable low: a write is not taken
      ce = 1'b0;
      i_mbcs_host.wr(5'h00, 16'h4000);
      ce = 1'b1;
      @(posedge ref_clk);
      #1 chk(16'(diag_loopback), 16'h0000);
      $display("control test done");
      // status ignores writes; an unmapped address reads 0
      i_mbcs_host.wr(5'h01, 16'h0000);
      i_mbcs_host.rd(5'h01, d);
      chk(d, 16'h7909);
      i_mbcs_host.rd(5'h10, d);
      chk(d, 16'h0000);
      $display("status test done");
      // collision test follows tx_en, then normal collision passes through
      i_mbcs_host.wr(5'h00, 16'h0080);
      tx_en = 1'b1;
      for (i = 0; i < 64 && col_out !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk(16'(col_out), 16'h0001);
      tx_en = 1'b0;
      @(posedge ref_clk);
      #1 chk(16'(col_out), 16'h0000);
      i_mbcs_host.wr(5'h00, 16'h0000);
      col_in = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(col_out), 16'h0001);
      col_in = 1'b0;
      $display("collision test done");
      finish_test;
   end
endmodule : mii_basic_control_status_regs_tb
